//--- rtl/afc_fan_ctrl.sv
// automatic fan drive: zone duty, spin-up, ramp limiting, pwm outputs
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
module afc_fan_ctrl import afc_pkg::*; #(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF,
  parameter int unsigned SPIN_UNIT_TICKS = SPIN_UNIT_TICKS_DEF,
  parameter afc_tbl_t RAMP_STEP_TICKS = RAMP_STEP_TICKS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [2:0][7:0] zone_temp_i,
  input wire logic temp_valid_i,
  input wire logic [3:0][15:0] tach_reading_i,
  output logic [2:0] fan_drive_o,
  output logic alert_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [8:0] tick_cnt;
  logic tick;
  logic [7:0] cfg [3];
  logic [7:0] rng [3];
  logic [7:0] min_duty [3];
  logic [7:0] low_temp [3];
  logic [7:0] opt [3];
  logic [7:0] man_duty [3];
  logic [7:0] ramp_a, ramp_b, hyst_a, hyst_b, config_r, tach_link, stat_en, status;
  logic [15:0] tach_min [4];
  logic [7:0] temp_q [3];
  logic [7:0] calc [3];
  logic [7:0] ramp [3];
  logic [7:0] duty_q [3];
  logic [7:0] cur_duty [3];
  logic [7:0] pwm_cnt [3];
  logic [3:0] pre_cnt [3];
  logic [14:0] step_cnt [3];
  logic [2:0] step;
  logic [16:0] spin_cnt [3];
  afc_spin_t state [3];
  logic [7:0] next_calc [3];
  logic [7:0] zone_d [3][3];
  logic [3:0] hyst [3];
  logic [3:0] ramp_sel [3];
  logic [2:0] tach_ok, spin_end;
  logic [7:0] st_set, st_clr;
  logic [31:0] rd_mux;
  logic wr_go;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] zone_duty(input logic [7:0] t, input logic [7:0] lo,
                                           input logic [7:0] mn, input logic [3:0] hy,
                                           input logic [2:0] rc, input logic keep_min,
                                           input logic running);
    logic [8:0] over;
    logic [15:0] prod;
    over = 9'h000;
    prod = 16'h0000;
    if (t >= lo) begin
      over = {1'b0, t} - {1'b0, lo};
      if (over >= (9'h002 << rc)) begin
        zone_duty = DUTY_FULL;
      end else begin
        prod = 16'(DUTY_FULL - mn) * 16'(over[7:0]);
        prod = prod >> (4'(rc) + 4'h1);
        zone_duty = mn + prod[7:0];
      end
    end else if (running && ({1'b0, t} + 9'(hy) >= {1'b0, lo})) begin
      zone_duty = mn;
    end else begin
      zone_duty = keep_min ? mn : DUTY_OFF;
    end
  endfunction : zone_duty

  function automatic logic [7:0] max2(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction : max2

  // ----------------------------------------
  // 90 kHz tick
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 9'h000;
      tick <= 1'b0;
    end else if (ce_i) begin
      tick <= (tick_cnt == 9'(TICK_DIV - 1));
      tick_cnt <= (tick_cnt == 9'(TICK_DIV - 1)) ? 9'h000 : tick_cnt + 9'h001;
    end
  end

  // ----------------------------------------
  // duty calculation and spin-up decision
  // ----------------------------------------
  always_comb begin
    hyst[0] = hyst_a[7:4];
    hyst[1] = hyst_a[3:0];
    hyst[2] = hyst_b[7:4];
    ramp_sel[0] = ramp_a[3:0];
    ramp_sel[1] = ramp_b[7:4];
    ramp_sel[2] = ramp_b[3:0];
    for (int o = 0; o < 3; o++) begin
      for (int z = 0; z < 3; z++) begin
        zone_d[o][z] = zone_duty(temp_q[z], low_temp[z], min_duty[o], hyst[z],
                                 rng[z][RNG_CODE_MSB:RNG_CODE_LSB],
                                 ramp_a[RAMP_MINOFF_LSB + o], calc[o] != DUTY_OFF);
      end
      case (afc_zone_t'(cfg[o][CFG_ZONE_MSB:CFG_ZONE_LSB]))
        ZM_ZONE1: next_calc[o] = zone_d[o][0];
        ZM_ZONE2: next_calc[o] = zone_d[o][1];
        ZM_ZONE3: next_calc[o] = zone_d[o][2];
        ZM_FULL: next_calc[o] = DUTY_FULL;
        ZM_HOT23: next_calc[o] = max2(zone_d[o][1], zone_d[o][2]);
        ZM_HOTALL: next_calc[o] = max2(zone_d[o][0], max2(zone_d[o][1], zone_d[o][2]));
        ZM_MANUAL: next_calc[o] = man_duty[o];
        default: next_calc[o] = DUTY_OFF;
      endcase
      tach_ok[o] = 1'b1;
      for (int t = 0; t < 4; t++) begin
        if (tach_link[2 * t +: 2] == 2'(o) && tach_reading_i[t] >= tach_min[t]) begin
          tach_ok[o] = 1'b0;
        end
      end
      // reduction ends spin on valid tachs, otherwise the timer does
      spin_end[o] = tick && state[o] == SP_SPIN && calc[o] != DUTY_OFF &&
                    ((config_r[CONFIG_SPINRED_BIT] && tach_ok[o]) ||
                     spin_cnt[o] == 17'h00001);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int z = 0; z < 3; z++) begin
        temp_q[z] <= 8'h00;
      end
    end else if (ce_i && temp_valid_i) begin
      for (int z = 0; z < 3; z++) begin
        temp_q[z] <= zone_temp_i[z];
      end
    end
  end

  // ----------------------------------------
  // free-running ramp step timers
  // ----------------------------------------
  // not tied to the pwm period, so step timing holds when the pwm rate changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step <= 3'h0;
      for (int o = 0; o < 3; o++) begin
        step_cnt[o] <= 15'h0000;
      end
    end else if (ce_i && tick) begin
      for (int o = 0; o < 3; o++) begin
        if (step_cnt[o] >= 15'(RAMP_STEP_TICKS[ramp_sel[o][2:0]] - 1)) begin
          step_cnt[o] <= 15'h0000;
          step[o] <= 1'b1;
        end else begin
          step_cnt[o] <= step_cnt[o] + 15'h0001;
          step[o] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // spin-up and ramp state per output
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int o = 0; o < 3; o++) begin
        state[o] <= SP_OFF;
        calc[o] <= DUTY_OFF;
        ramp[o] <= DUTY_OFF;
        spin_cnt[o] <= 17'h00000;
      end
    end else if (ce_i && tick) begin
      for (int o = 0; o < 3; o++) begin
        calc[o] <= next_calc[o];
        case (state[o])
          SP_OFF: begin
            if (calc[o] != DUTY_OFF) begin
              state[o] <= SP_SPIN;
              spin_cnt[o] <= 17'(SPIN_UNIT_TICKS * (32'(cfg[o][CFG_SPIN_MSB:0]) + 1));
            end
          end
          SP_SPIN: begin
            if (calc[o] == DUTY_OFF) begin
              state[o] <= SP_OFF;
            end else if (spin_end[o]) begin
              state[o] <= SP_RUN;
              ramp[o] <= calc[o];
            end else begin
              spin_cnt[o] <= spin_cnt[o] - 17'h00001;
            end
          end
          SP_RUN: begin
            if (calc[o] == DUTY_OFF && !opt[o][OPT_RAMP_OFF_BIT]) begin
              ramp[o] <= DUTY_OFF;
              state[o] <= SP_OFF;
            end else if (!ramp_sel[o][RAMP_EN_BIT]) begin
              ramp[o] <= calc[o];
              if (calc[o] == DUTY_OFF) begin
                state[o] <= SP_OFF;
              end
            end else if (ramp[o] == DUTY_OFF) begin
              state[o] <= SP_OFF;
            end else if (step[o]) begin
              // single unit step, stops at the target so it never overshoots
              if (ramp[o] < calc[o]) begin
                ramp[o] <= ramp[o] + 8'h01;
              end else if (ramp[o] > calc[o]) begin
                ramp[o] <= ramp[o] - 8'h01;
              end
            end
          end
          default: state[o] <= SP_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------
  // pwm generators
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fan_drive_o <= 3'h0;
      for (int o = 0; o < 3; o++) begin
        pre_cnt[o] <= 4'h0;
        pwm_cnt[o] <= 8'h00;
        duty_q[o] <= DUTY_OFF;
        cur_duty[o] <= DUTY_OFF;
      end
    end else if (ce_i) begin
      for (int o = 0; o < 3; o++) begin
        if (tick) begin
          if (pre_cnt[o] == rng[o][RNG_PRE_MSB:0]) begin
            pre_cnt[o] <= 4'h0;
            pwm_cnt[o] <= pwm_cnt[o] + 8'h01;
            if (pwm_cnt[o] == DUTY_FULL) begin
              duty_q[o] <= ramp[o];
              cur_duty[o] <= (state[o] == SP_SPIN) ? DUTY_OFF : ramp[o];
            end
          end else begin
            pre_cnt[o] <= pre_cnt[o] + 4'h1;
          end
        end
        if (spin_end[o]) begin
          duty_q[o] <= calc[o];
          cur_duty[o] <= calc[o];
        end
        // high while count below duty: duty ff gives 255 high, 1 low
        fan_drive_o[o] <= (state[o] == SP_SPIN) || (pwm_cnt[o] < duty_q[o]);
      end
    end
  end

  // ----------------------------------------
  // status and alert
  // ----------------------------------------
  always_comb begin
    st_set = 8'h00;
    for (int o = 0; o < 3; o++) begin
      st_set[o] = spin_end[o] && !tach_ok[o];
    end
    for (int t = 0; t < 4; t++) begin
      if (tick && tach_link[2 * t +: 2] != TACH_NONE &&
          tach_reading_i[t] > tach_min[t] &&
          state[tach_link[2 * t +: 2]] != SP_SPIN) begin
        st_set[ST_TACH_LSB + t] = 1'b1;
      end
    end
    st_clr = (wr_go && avs_address_i == REG_STATUS) ? avs_writedata_i[7:0] : 8'h00;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 8'h00;
      alert_o <= 1'b0;
    end else if (ce_i) begin
      // a new event beats a clear in the same cycle
      status <= (status & ~st_clr) | st_set;
      alert_o <= config_r[CONFIG_ALERT_BIT] && |(status & stat_en);
    end
  end

  // ----------------------------------------
  // avalon slave: one wait state on every access
  // ----------------------------------------
  assign wr_go = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

  always_comb begin
    rd_mux = 32'h00000000;
    for (int o = 0; o < 3; o++) begin
      if (avs_address_i == REG_CUR_DUTY0 + 8'(o)) rd_mux = {24'h000000, cur_duty[o]};
      if (avs_address_i == REG_CFG0 + 8'(o)) rd_mux = {24'h000000, cfg[o]};
      if (avs_address_i == REG_RANGE0 + 8'(o)) rd_mux = {24'h000000, rng[o]};
      if (avs_address_i == REG_MIN_DUTY0 + 8'(o)) rd_mux = {24'h000000, min_duty[o]};
      if (avs_address_i == REG_LOW_TEMP0 + 8'(o)) rd_mux = {24'h000000, low_temp[o]};
      if (avs_address_i == REG_OPT0 + 8'(o)) rd_mux = {24'h000000, opt[o]};
    end
    for (int t = 0; t < 4; t++) begin
      if (avs_address_i == REG_TACH_MIN0 + 8'(t)) rd_mux = {16'h0000, tach_min[t]};
    end
    case (avs_address_i)
      REG_STATUS: rd_mux = {24'h000000, status};
      REG_STAT_EN: rd_mux = {24'h000000, stat_en};
      REG_RAMP_A: rd_mux = {24'h000000, ramp_a};
      REG_RAMP_B: rd_mux = {24'h000000, ramp_b};
      REG_HYST_A: rd_mux = {24'h000000, hyst_a};
      REG_HYST_B: rd_mux = {24'h000000, hyst_b};
      REG_CONFIG: rd_mux = {24'h000000, config_r};
      REG_TACH_LINK: rd_mux = {24'h000000, tach_link};
      default: ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else if (ce_i) begin
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= rd_mux;
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_a <= 8'h00;
      ramp_b <= 8'h00;
      hyst_a <= HYST_RST;
      hyst_b <= HYST_RST;
      config_r <= CONFIG_RST;
      tach_link <= TACH_LINK_RST;
      stat_en <= STAT_EN_RST;
      for (int o = 0; o < 3; o++) begin
        cfg[o] <= CFG_RST;
        rng[o] <= RANGE_RST;
        min_duty[o] <= MIN_DUTY_RST;
        low_temp[o] <= LOW_TEMP_RST;
        opt[o] <= 8'h00;
        man_duty[o] <= DUTY_OFF;
      end
      for (int t = 0; t < 4; t++) begin
        tach_min[t] <= TACH_MIN_RST;
      end
    end else if (ce_i && wr_go) begin
      for (int o = 0; o < 3; o++) begin
        if (avs_address_i == REG_CUR_DUTY0 + 8'(o)) man_duty[o] <= avs_writedata_i[7:0];
        if (avs_address_i == REG_CFG0 + 8'(o)) cfg[o] <= avs_writedata_i[7:0];
        if (avs_address_i == REG_RANGE0 + 8'(o)) rng[o] <= avs_writedata_i[7:0];
        if (avs_address_i == REG_MIN_DUTY0 + 8'(o)) min_duty[o] <= avs_writedata_i[7:0];
        if (avs_address_i == REG_LOW_TEMP0 + 8'(o)) low_temp[o] <= avs_writedata_i[7:0];
        if (avs_address_i == REG_OPT0 + 8'(o)) opt[o] <= avs_writedata_i[7:0];
      end
      for (int t = 0; t < 4; t++) begin
        if (avs_address_i == REG_TACH_MIN0 + 8'(t)) begin
          tach_min[t][7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) tach_min[t][15:8] <= avs_writedata_i[15:8];
        end
      end
      case (avs_address_i)
        REG_STAT_EN: stat_en <= avs_writedata_i[7:0];
        REG_RAMP_A: ramp_a <= avs_writedata_i[7:0];
        REG_RAMP_B: ramp_b <= avs_writedata_i[7:0];
        REG_HYST_A: hyst_a <= avs_writedata_i[7:0];
        REG_HYST_B: hyst_b <= avs_writedata_i[7:0];
        REG_CONFIG: config_r <= avs_writedata_i[7:0];
        REG_TACH_LINK: tach_link <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end
endmodule : afc_fan_ctrl

//--- rtl/afc_pkg.sv
// constants, types and register map of the automatic fan controller
package afc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_HZ = 90_000;
  localparam int unsigned TICK_DIV_DEF = CLK_HZ / TICK_HZ;
  localparam int unsigned SPIN_UNIT_MS = 100;
  localparam int unsigned SPIN_UNIT_TICKS_DEF = SPIN_UNIT_MS * TICK_HZ / 1000;
  typedef int unsigned afc_tbl_t [8];
  localparam afc_tbl_t RAMP_STEP_MS = '{206, 104, 69, 41, 26, 18, 10, 5};

  function automatic afc_tbl_t afc_ms_to_ticks(input afc_tbl_t ms);
    afc_tbl_t t;
    for (int i = 0; i < 8; i++) begin
      t[i] = ms[i] * TICK_HZ / 1000;
    end
    return t;
  endfunction : afc_ms_to_ticks

  localparam afc_tbl_t RAMP_STEP_TICKS_DEF = afc_ms_to_ticks(RAMP_STEP_MS);

  // ----------------------------------------
  // register indices (word address)
  // ----------------------------------------
  localparam logic [7:0] REG_CUR_DUTY0 = 8'h30;
  localparam logic [7:0] REG_STATUS = 8'h42;
  localparam logic [7:0] REG_STAT_EN = 8'h43;
  localparam logic [7:0] REG_CFG0 = 8'h5c;
  localparam logic [7:0] REG_RANGE0 = 8'h5f;
  localparam logic [7:0] REG_RAMP_A = 8'h62;
  localparam logic [7:0] REG_RAMP_B = 8'h63;
  localparam logic [7:0] REG_MIN_DUTY0 = 8'h64;
  localparam logic [7:0] REG_LOW_TEMP0 = 8'h67;
  localparam logic [7:0] REG_HYST_A = 8'h6d;
  localparam logic [7:0] REG_HYST_B = 8'h6e;
  localparam logic [7:0] REG_CONFIG = 8'h7f;
  localparam logic [7:0] REG_TACH_LINK = 8'h81;
  localparam logic [7:0] REG_OPT0 = 8'h94;
  localparam logic [7:0] REG_TACH_MIN0 = 8'ha0;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int CFG_ZONE_LSB = 5;
  localparam int CFG_ZONE_MSB = 7;
  localparam int CFG_SPIN_MSB = 2;
  localparam int RNG_CODE_LSB = 4;
  localparam int RNG_CODE_MSB = 6;
  localparam int RNG_PRE_MSB = 3;
  localparam int RAMP_MINOFF_LSB = 5;
  localparam int RAMP_EN_BIT = 3;
  localparam int CONFIG_ALERT_BIT = 0;
  localparam int CONFIG_SPINRED_BIT = 4;
  localparam int OPT_RAMP_OFF_BIT = 3;
  localparam int ST_TACH_LSB = 3;
  localparam logic [7:0] CFG_RST = 8'h62;
  localparam logic [7:0] RANGE_RST = 8'h40;
  localparam logic [7:0] MIN_DUTY_RST = 8'h80;
  localparam logic [7:0] LOW_TEMP_RST = 8'h5a;
  localparam logic [7:0] HYST_RST = 8'h44;
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [7:0] TACH_LINK_RST = 8'he4;
  localparam logic [7:0] STAT_EN_RST = 8'h7f;
  localparam logic [15:0] TACH_MIN_RST = 16'hffff;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] DUTY_OFF = 8'h00;
  localparam logic [1:0] TACH_NONE = 2'b11;

  typedef enum logic [2:0] {
    ZM_ZONE1 = 3'b000, ZM_ZONE2 = 3'b001, ZM_ZONE3 = 3'b010, ZM_FULL = 3'b011,
    ZM_OFF = 3'b100, ZM_HOT23 = 3'b101, ZM_HOTALL = 3'b110, ZM_MANUAL = 3'b111
  } afc_zone_t;

  typedef enum logic [1:0] {
    SP_OFF = 2'b00, SP_SPIN = 2'b01, SP_RUN = 2'b10
  } afc_spin_t;
endpackage : afc_pkg

//--- tb/afc_fan_ctrl_properties.sv
// port-level assertions for the automatic fan controller
module afc_fan_ctrl_properties import afc_pkg::*; #(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [2:0] fan_drive_o,
  input wire logic alert_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic alert_en;
  logic [11:0] lo_run;
  logic [11:0] hi_run;
  always_ff @(posedge clk_i) begin
    if (rst_i) alert_en <= 1'b0;
    else if (ce_i && avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
             avs_address_i == REG_CONFIG) alert_en <= avs_writedata_i[CONFIG_ALERT_BIT];
  end
  // counters saturate so a long off phase never wraps into a short one
  always_ff @(posedge clk_i) begin
    if (rst_i || fan_drive_o[0]) lo_run <= 12'h000;
    else if (lo_run != 12'hfff) lo_run <= lo_run + 12'h001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !fan_drive_o[0]) hi_run <= 12'h000;
    else if (hi_run != 12'hfff) hi_run <= hi_run + 12'h001;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_wait_answer; (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
    |=> !avs_waitrequest_o; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after one wait");
  property p_wait_one; !avs_waitrequest_o && ce_i |=> avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wait_cause; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_rd_hold; avs_waitrequest_o && !avs_read_i && !avs_write_i
    |=> $stable(avs_readdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; !avs_waitrequest_o && avs_read_i && avs_address_i == 8'h00
    |-> avs_readdata_o == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ce_freeze; !ce_i |=> $stable(fan_drive_o) && $stable(alert_o) &&
    $stable(avs_waitrequest_o); endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("moved while frozen");
  property p_alert_gate; alert_o |-> alert_en || $past(alert_en) || $past(alert_en, 2);
  endproperty
  a_alert_gate: assert property (p_alert_gate) else $error("alert while disabled");
  property p_pwm_low; $rose(fan_drive_o[0]) |-> lo_run >= 12'(TICK_DIV); endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("low pulse short");
  property p_pwm_high; $fell(fan_drive_o[0]) |-> hi_run >= 12'(TICK_DIV); endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("high pulse short");
  property p_rst_quiet; @(posedge clk_i) disable iff (1'b0) rst_i
    |=> fan_drive_o == 3'b000 && !alert_o && avs_waitrequest_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
endmodule : afc_fan_ctrl_properties

bind afc_fan_ctrl afc_fan_ctrl_properties #(.TICK_DIV(TICK_DIV)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .fan_drive_o(fan_drive_o), .alert_o(alert_o));

//--- tb/afc_fan_model.sv
// behavioural fans whose tach readings follow the drive pins
module afc_fan_model #(
  parameter int SPIN_CLKS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] drive_i,
  input wire logic [3:0] stall_i,
  output logic [3:0][15:0] tach_o
);
  // rotor speed rises while driven and coasts down otherwise; tach 3 sits on fan 0
  logic [3:0][6:0] speed;
  always_ff @(posedge clk_i) begin
    for (int t = 0; t < 4; t++) begin
      if (rst_i) speed[t] <= 7'h00;
      else if (drive_i[t % 3] && speed[t] != 7'h7f) speed[t] <= speed[t] + 7'h01;
      else if (!drive_i[t % 3] && speed[t] != 7'h00) speed[t] <= speed[t] - 7'h01;
    end
  end
  always_comb begin
    for (int t = 0; t < 4; t++) begin
      tach_o[t] = (speed[t] >= 7'(SPIN_CLKS) && !stall_i[t]) ? 16'h0800 : 16'hffff;
    end
  end
endmodule : afc_fan_model

//--- tb/test_auto_fan_spinup_ramp_control.sv
// self-checking bench for the automatic fan controller
module test_auto_fan_spinup_ramp_control import afc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals, design and fan model
  // ----------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic temp_valid_i = 1'b0, avs_waitrequest_o, alert_o;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [3:0] avs_byteenable_i = 4'hf, stall = 4'h0;
  logic [2:0][7:0] zone_temp_i = '0;
  logic [3:0][15:0] tach_reading_i;
  logic [2:0] fan_drive_o;
  int miscompares = 0, comparisons = 0;
  logic [7:0] ra [14] = '{8'h5c, 8'h5f, 8'h62, 8'h63, 8'h64, 8'h67, 8'h6d, 8'h6e, 8'h7f,
    8'h81, 8'h94, 8'h42, 8'h43, 8'ha0};
  logic [15:0] rv [14] = '{16'h62, 16'h40, 16'h0, 16'h0, 16'h80, 16'h5a, 16'h44, 16'h44,
    16'h10, 16'he4, 16'h0, 16'h0, 16'h7f, 16'hffff};
  logic [7:0] hc [5] = '{8'ha7, 8'ha7, 8'hc7, 8'h47, 8'h07};
  logic [23:0] ht [5] = '{24'h5a5a7a, 24'h7a5a5a, 24'h5a5a7a, 24'h7a5a5a, 24'h5a5a7a};
  logic [7:0] he [5] = '{8'h80, 8'hff, 8'hff, 8'hff, 8'hff};
  initial forever #12.5 clk_i = ~clk_i;
  afc_fan_ctrl #(.TICK_DIV(4), .SPIN_UNIT_TICKS(3), .RAMP_STEP_TICKS('{4, 3, 2, 1, 1, 1, 1, 1}))
  DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .zone_temp_i(zone_temp_i),
    .temp_valid_i(temp_valid_i), .tach_reading_i(tach_reading_i),
    .fan_drive_o(fan_drive_o), .alert_o(alert_o));
  afc_fan_model u_fan (.clk_i(clk_i), .rst_i(rst_i), .drive_i(fan_drive_o), .stall_i(stall),
    .tach_o(tach_reading_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  // an idle edge follows so strobes never toggle twice
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                     output logic [31:0] rd);
    int n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, wd};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      chk("waitrequest", 32'(avs_waitrequest_o), 32'h0);
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 16'h0, x);
    chk(w, x, e);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  task automatic temps(input logic [23:0] t);
    zone_temp_i <= t;
    temp_valid_i <= 1'b1;
    @(posedge clk_i);
    temp_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask : temps
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    int c;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) rchk($sformatf("reg %h", ra[i]), ra[i], 32'(rv[i]));
    wr(8'h00, 16'h00a5);
    rchk("unmapped", 8'h00, 32'h0);
    avs_byteenable_i <= 4'h2;
    wr(REG_STAT_EN, 16'h0000);
    avs_byteenable_i <= 4'hf;
    rchk("masked write", REG_STAT_EN, 32'h7f);
    ce_i <= 1'b0;
    idle(3);
    ce_i <= 1'b1;
    idle(1100);
    rchk("full duty", REG_CUR_DUTY0, 32'hff);
    c = 0;
    repeat (2048) begin
      @(posedge clk_i);
      if (fan_drive_o[0] === 1'b0) c++;
    end
    chk("low clocks", 32'(c), 32'h8);
    $display("test defaults done");
    for (int k = 0; k < 2; k++) begin
      wr(REG_CFG0, 16'h87);
      idle(1100);
      rchk("off duty", REG_CUR_DUTY0, 32'h0);
      wr(REG_CFG0, 16'h67);
      idle(k == 0 ? 12 : 52);
      chk("spin drive", {31'h0, fan_drive_o[0]}, 32'h1);
      rchk("spin duty", REG_CUR_DUTY0, 32'h0);
      idle(k == 0 ? 40 : 100);
      rchk("after spin", REG_CUR_DUTY0, 32'hff);
      wr(REG_CONFIG, 16'h00);
    end
    wr(REG_CONFIG, 16'h11);
    $display("test spin-up done");
    wr(REG_TACH_LINK, 16'h24);
    stall <= 4'h8;
    wr(REG_CFG0, 16'h87);
    idle(1100);
    wr(REG_CFG0, 16'h67);
    idle(40);
    rchk("status in spin", REG_STATUS, 32'h0);
    idle(100);
    rchk("spin fail", REG_STATUS, 32'h1);
    chk("alert on", {31'h0, alert_o}, 32'h1);
    wr(REG_STAT_EN, 16'h00);
    idle(4);
    chk("alert masked", {31'h0, alert_o}, 32'h0);
    wr(REG_STATUS, 16'h01);
    wr(REG_STAT_EN, 16'h7f);
    stall <= 4'h0;
    $display("test spin fail done");
    for (int i = 0; i < 5; i++) begin
      wr(REG_CFG0, 16'(hc[i]));
      temps(ht[i]);
      idle(1100);
      rchk($sformatf("zone row %0d", i), REG_CUR_DUTY0, 32'(he[i]));
    end
    temps(24'h5a5a57);
    idle(1100);
    rchk("hysteresis on", REG_CUR_DUTY0, 32'h80);
    temps(24'h5a5a50);
    idle(1100);
    rchk("below off", REG_CUR_DUTY0, 32'h0);
    wr(REG_RAMP_A, 16'h20);
    idle(1100);
    rchk("below min", REG_CUR_DUTY0, 32'h80);
    $display("test zones done");
    wr(REG_RAMP_A, 16'h28);
    temps(24'h5a5a7a);
    idle(1300);
    bus(1'b0, REG_CUR_DUTY0, 16'h0, d);
    chk("ramp mid", {31'h0, d > 32'h80 && d < 32'hff}, 32'h1);
    idle(2000);
    rchk("ramp top", REG_CUR_DUTY0, 32'hff);
    wr(REG_RAMP_A, 16'h0b);
    temps(24'h5a5a5a);
    idle(1600);
    rchk("fast ramp", REG_CUR_DUTY0, 32'h80);
    wr(REG_RAMP_A, 16'h08);
    wr(REG_OPT0, 16'h08);
    wr(REG_CFG0, 16'h87);
    idle(1300);
    bus(1'b0, REG_CUR_DUTY0, 16'h0, d);
    chk("ramp to off", {31'h0, d > 32'h0 && d < 32'h80}, 32'h1);
    idle(2000);
    rchk("ramped off", REG_CUR_DUTY0, 32'h0);
    wr(REG_OPT0, 16'h00);
    temps(24'h5a7a5a);
    wr(REG_CFG0, 16'h27);
    idle(300);
    rchk("start no ramp", REG_CUR_DUTY0, 32'hff);
    wr(REG_CFG0, 16'h87);
    idle(1100);
    rchk("jump off", REG_CUR_DUTY0, 32'h0);
    wr(REG_CUR_DUTY0, 16'h40);
    wr(REG_CFG0, 16'he7);
    idle(300);
    rchk("manual", REG_CUR_DUTY0, 32'h40);
    $display("test ramp done");
    tally_and_finish();
  end
endmodule : test_auto_fan_spinup_ramp_control
